// ### shared/hcf_pkg.sv
// Constants, register map and field layout of the channel data path
package hcf_pkg;
	localparam int HCF_NCH = 4;
	localparam int HCF_BANK = 32;
	localparam int HCF_FIFO_DEPTH = 2 * HCF_BANK;
	// Common registers, 7-bit bus addresses
	localparam logic [6:0] HCF_ADDR_CONFIG = 7'h1f;
	localparam logic [6:0] HCF_ADDR_VECTOR = 7'h36;
	localparam logic [6:0] HCF_ADDR_ADDR_CMP = 7'h3d;
	localparam logic [6:0] HCF_ADDR_SRC_MASK = 7'h3e;
	// Per-channel offsets inside the 32-byte channel window
	localparam logic [4:0] HCF_OFS_FIFO_LAST = 5'h0f;
	localparam logic [4:0] HCF_OFS_FLAGS = 5'h10;
	localparam logic [4:0] HCF_OFS_CMD = 5'h11;
	localparam logic [4:0] HCF_OFS_TALLY = 5'h15;
	localparam int HCF_CFG_VIS_BIT = 5;
	localparam int HCF_STAT_XFW_BIT = 6;
	localparam int HCF_STAT_SEND_BIT = 2;
	// Command codes
	localparam logic [7:0] HCF_CMD_RX_RELEASE = 8'h80;
	localparam logic [7:0] HCF_CMD_TX_GO = 8'h08;
	localparam logic [7:0] HCF_CMD_TX_GO_CLOSE = 8'h0a;
	localparam logic [7:0] HCF_CMD_TX_ABORT = 8'h01;
	// Event flag positions
	localparam int HCF_EV_RX_END = 0;
	localparam int HCF_EV_RX_FULL = 1;
	localparam int HCF_EV_RX_LOST = 2;
	localparam int HCF_EV_TX_SPACE = 3;
	localparam int HCF_EV_TX_UNDER = 4;
	localparam int HCF_NEV = 5;
	// Status byte appended after each frame not dropped by address compare
	localparam int HCF_STB_ABORT = 7;
	localparam int HCF_STB_LOST = 6;
	localparam int HCF_STB_CRC_OK = 5;
	localparam logic [2:0] HCF_BLOCKS_MAX = 3'h7;
	localparam logic [7:0] HCF_RST_BYTE = 8'h00;
	localparam logic [7:0] HCF_OE_NONE = 8'h00;
endpackage : hcf_pkg

// ### hdl/hcf_fifo.sv
// Flop-based first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
module hcf_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic clr,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [$clog2(D+1)-1:0] count
);
	localparam int AW = $clog2(D);
	localparam int CW = $clog2(D+1);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
		logic room;
		logic any;
	} hcf_fifo_st_t;
	hcf_fifo_st_t s_reg, s_next;
	logic push, pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : ptr_inc

	assign in_ready = s_reg.room;
	assign out_valid = s_reg.any;
	assign out_data = s_reg.mem[s_reg.rp];
	assign count = s_reg.cnt;

	always_comb
	begin
		s_next = s_reg;
		push = in_valid && s_reg.room;
		pop = out_ready && s_reg.any;
		if (push)
		begin
			s_next.mem[s_reg.wp] = in_data;
			s_next.wp = ptr_inc(s_reg.wp);
		end
		if (pop)
			s_next.rp = ptr_inc(s_reg.rp);
		s_next.cnt = CW'(s_reg.cnt + CW'(push) - CW'(pop));
		if (clr)
		begin
			s_next.wp = '0;
			s_next.rp = '0;
			s_next.cnt = '0;
		end
		s_next.room = (s_next.cnt != CW'(D));
		s_next.any = (s_next.cnt != '0);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_reg <= '0;
			s_reg.room <= 1'b1;
		end
		else if (ce)
			s_reg <= s_next;
	end
endmodule : hcf_fifo

// ### hdl/hcf_evt.sv
// One channel's pending event causes with cause and channel masking
`timescale 1ns/100ps
module hcf_evt
	import hcf_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [HCF_NEV-1:0] set,
	input wire logic [HCF_NEV-1:0] ev_mask,
	input wire logic src_mask,
	input wire logic rd_clr,
	output logic [HCF_NEV-1:0] shown
);
	typedef struct packed {
		logic [HCF_NEV-1:0] pend;
	} hcf_evt_st_t;
	hcf_evt_st_t s_reg, s_next;

	// Masked causes are kept, only hidden
	assign shown = src_mask ? '0 : (s_reg.pend & ~ev_mask);

	always_comb
	begin
		s_next = s_reg;
		if (rd_clr)
			s_next.pend = s_reg.pend & ~shown;
		// A new cause in the clearing cycle survives
		s_next.pend = s_next.pend | set;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s_reg <= '0;
		else if (ce)
			s_reg <= s_next;
	end
endmodule : hcf_evt

// ### hdl/hcf_top.sv
// Host-side receive/transmit data path and events of four HDLC channels
`timescale 1ns/100ps
module hcf_top
	import hcf_pkg::*;
#(
	parameter int NCH = HCF_NCH,
	parameter int DEPTH = HCF_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic bus_cs,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic [6:0] bus_addr,
	input wire logic [7:0] bus_din,
	output logic [7:0] bus_dout,
	output logic [7:0] bus_oe,
	output logic int_n,
	input wire logic [NCH-1:0] rx_valid,
	input wire logic [NCH*8-1:0] rx_data,
	input wire logic [NCH-1:0] rx_last,
	input wire logic [NCH-1:0] rx_abort,
	input wire logic [NCH-1:0] rx_crc_ok,
	input wire logic [NCH-1:0] rx_addr_ok,
	output logic [NCH-1:0] rx_ready,
	output logic [NCH-1:0] tx_valid,
	output logic [NCH*8-1:0] tx_data,
	input wire logic [NCH-1:0] tx_ready,
	output logic [NCH-1:0] tx_close,
	output logic [NCH-1:0] tx_abort
);
	localparam int CW = $clog2(DEPTH+1);
	localparam int DQW = 9;
	localparam logic [CW-1:0] BANK_C = CW'(HCF_BANK);
	localparam logic [5:0] BANK_6 = 6'(HCF_BANK);
	localparam logic [6:0] BANK_7 = 7'(HCF_BANK);

	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe;
		logic int_n;
		logic vis_sel;
		logic [NCH-1:0] src_mask;
		logic [NCH-1:0] acmp;
		logic [NCH-1:0][HCF_NEV-1:0] ev_mask;
		logic [NCH-1:0] in_frame;
		logic [NCH-1:0] ignore;
		logic [NCH-1:0] lost;
		logic [NCH-1:0][5:0] blk_cnt;
		logic [NCH-1:0][2:0] blocks;
		logic [NCH-1:0] cur_valid;
		logic [NCH-1:0] cur_end;
		logic [NCH-1:0][5:0] remain;
		logic [NCH-1:0][5:0] disc;
		logic [NCH-1:0][7:0] tally;
		logic [NCH-1:0][6:0] wr_cnt;
		logic [NCH-1:0][6:0] rel;
		logic [NCH-1:0] close_pend;
		logic [NCH-1:0] sending;
		logic [NCH-1:0] space_armed;
		logic [NCH-1:0] tx_v;
		logic [NCH-1:0][7:0] tx_d;
		logic [NCH-1:0] tx_cl;
		logic [NCH-1:0] tx_ab;
	} hcf_top_st_t;
	hcf_top_st_t s_reg, s_next;

	logic [NCH-1:0] rxf_push, rxf_rdy, rxf_vld, rxf_pop;
	logic [NCH-1:0][7:0] rxf_din, rxf_dout;
	logic [NCH-1:0] txf_push, txf_rdy, txf_vld, txf_pop, txf_clr;
	logic [NCH-1:0][7:0] txf_dout;
	logic [NCH-1:0][CW-1:0] txf_cnt;
	logic [NCH-1:0] dq_push, dq_vld, dq_pop;
	logic [NCH-1:0][DQW-1:0] dq_din, dq_dout;
	logic [NCH-1:0][HCF_NEV-1:0] ev_set, ev_shown;
	logic [NCH-1:0] ev_rdclr;

	function automatic logic [2:0] sat_inc3(input logic [2:0] v);
		sat_inc3 = (v == HCF_BLOCKS_MAX) ? v : 3'(v + 1'b1);
	endfunction : sat_inc3

	function automatic logic is_ch_reg(input logic [6:0] a, input int c,
		input logic [4:0] ofs);
		is_ch_reg = (a[6:5] == 2'(c)) && (a[4:0] == ofs);
	endfunction : is_ch_reg

	function automatic logic is_ch_fifo(input logic [6:0] a, input int c);
		is_ch_fifo = (a[6:5] == 2'(c)) && (a[4:0] <= HCF_OFS_FIFO_LAST);
	endfunction : is_ch_fifo

	////////////////////////////////////////////////////////////////////////
	// Per-channel buffers and event flags

	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		// Two banks of 32 bytes each way
		hcf_fifo #(.W(8), .D(DEPTH)) u_rxf (
			.clk(clk), .rst(rst), .ce(ce), .clr(1'b0),
			.in_valid(rxf_push[c]), .in_ready(rxf_rdy[c]),
			.in_data(rxf_din[c]),
			.out_valid(rxf_vld[c]), .out_ready(rxf_pop[c]),
			.out_data(rxf_dout[c]), .count()
		);
		hcf_fifo #(.W(8), .D(DEPTH)) u_txf (
			.clk(clk), .rst(rst), .ce(ce), .clr(txf_clr[c]),
			.in_valid(txf_push[c]), .in_ready(txf_rdy[c]),
			.in_data(bus_din),
			.out_valid(txf_vld[c]), .out_ready(txf_pop[c]),
			.out_data(txf_dout[c]), .count(txf_cnt[c])
		);
		// Each descriptor owns at least one stored byte, so it never fills
		hcf_fifo #(.W(DQW), .D(DEPTH)) u_dq (
			.clk(clk), .rst(rst), .ce(ce), .clr(1'b0),
			.in_valid(dq_push[c]), .in_ready(),
			.in_data(dq_din[c]),
			.out_valid(dq_vld[c]), .out_ready(dq_pop[c]),
			.out_data(dq_dout[c]), .count()
		);
		hcf_evt u_evt (
			.clk(clk), .rst(rst), .ce(ce),
			.set(ev_set[c]), .ev_mask(s_reg.ev_mask[c]),
			.src_mask(s_reg.src_mask[c]), .rd_clr(ev_rdclr[c]),
			.shown(ev_shown[c])
		);
		assign rx_ready[c] = rxf_rdy[c];
		assign tx_data[c*8 +: 8] = s_reg.tx_d[c];
	end

	assign bus_dout = s_reg.dout;
	assign bus_oe = s_reg.oe;
	assign int_n = s_reg.int_n;
	assign tx_valid = s_reg.tx_v;
	assign tx_close = s_reg.tx_cl;
	assign tx_abort = s_reg.tx_ab;

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		logic rd, wr, any_ev, stage_free, cmd_hit;
		logic [NCH-1:0] vec;
		logic [7:0] rbyte;
		s_next = s_reg;
		rd = bus_cs && bus_rd;
		wr = bus_cs && bus_wr;
		any_ev = 1'b0;
		vec = '0;
		rbyte = HCF_RST_BYTE;
		rxf_push = '0;
		rxf_din = '0;
		rxf_pop = '0;
		txf_push = '0;
		txf_pop = '0;
		txf_clr = '0;
		dq_push = '0;
		dq_din = '0;
		dq_pop = '0;
		ev_set = '0;
		ev_rdclr = '0;
		s_next.oe = HCF_OE_NONE;
		s_next.dout = HCF_RST_BYTE;
		s_next.tx_cl = '0;
		s_next.tx_ab = '0;

		// Common registers
		if (wr && bus_addr == HCF_ADDR_CONFIG)
			s_next.vis_sel = bus_din[HCF_CFG_VIS_BIT];
		if (wr && bus_addr == HCF_ADDR_ADDR_CMP)
			s_next.acmp = bus_din[NCH-1:0];
		if (wr && bus_addr == HCF_ADDR_SRC_MASK)
			s_next.src_mask = bus_din[NCH-1:0];

		for (int c = 0; c < NCH; c++)
		begin
			// Receive: store every byte up to the CRC, except in an ignored frame or after a byte is lost
			if (rx_valid[c] && !rx_last[c])
			begin
				if (!s_reg.in_frame[c])
				begin
					s_next.in_frame[c] = 1'b1;
					s_next.ignore[c] = s_reg.acmp[c] && !rx_addr_ok[c];
				end
				if (s_next.ignore[c] || s_reg.lost[c])
					;
				else if (!rxf_rdy[c])
				begin
					s_next.lost[c] = 1'b1;
					ev_set[c][HCF_EV_RX_LOST] = 1'b1;
				end
				else
				begin
					rxf_push[c] = 1'b1;
					rxf_din[c] = rx_data[c*8 +: 8];
					s_next.blk_cnt[c] = 6'(s_reg.blk_cnt[c] + 1'b1);
					if (s_reg.blk_cnt[c] == BANK_6 - 1'b1)
					begin
						// Block full: queue a 32-byte delivery
						dq_push[c] = 1'b1;
						dq_din[c] = {1'b0, s_reg.blocks[c], 5'h00};
						s_next.blk_cnt[c] = '0;
						s_next.blocks[c] = sat_inc3(s_reg.blocks[c]);
					end
				end
			end
			// Status beat is held by the framer until there is room
			if (rx_valid[c] && rx_last[c] && rxf_rdy[c])
			begin
				s_next.in_frame[c] = 1'b0;
				s_next.ignore[c] = 1'b0;
				s_next.lost[c] = 1'b0;
				s_next.blk_cnt[c] = '0;
				s_next.blocks[c] = '0;
				if (!(s_reg.ignore[c] && s_reg.in_frame[c]))
				begin
					rxf_push[c] = 1'b1;
					rxf_din[c] = HCF_RST_BYTE;
					rxf_din[c][HCF_STB_ABORT] = rx_abort[c];
					rxf_din[c][HCF_STB_CRC_OK] = rx_crc_ok[c];
					rxf_din[c][HCF_STB_LOST] = s_reg.lost[c];
					dq_push[c] = 1'b1;
					dq_din[c] = {1'b1, s_reg.blocks[c],
						5'(s_reg.blk_cnt[c] + 1'b1)};
				end
			end

			// Present the next queued delivery only once the last is gone
			if (!s_reg.cur_valid[c] && s_reg.disc[c] == '0 && dq_vld[c])
			begin
				dq_pop[c] = 1'b1;
				s_next.cur_valid[c] = 1'b1;
				s_next.cur_end[c] = dq_dout[c][8];
				if (dq_dout[c][8])
				begin
					s_next.remain[c] = {1'b0, dq_dout[c][4:0]};
					s_next.tally[c] = dq_dout[c][7:0];
					ev_set[c][HCF_EV_RX_END] = 1'b1;
				end
				else
				begin
					s_next.remain[c] = BANK_6;
					ev_set[c][HCF_EV_RX_FULL] = 1'b1;
				end
			end
			// Unread bytes of a released block are dropped one per cycle
			if (s_reg.disc[c] != '0)
			begin
				rxf_pop[c] = 1'b1;
				s_next.disc[c] = 6'(s_reg.disc[c] - 1'b1);
			end

			// Transmit byte stage toward the framer
			stage_free = !s_reg.tx_v[c] || tx_ready[c];
			if (s_reg.tx_v[c] && tx_ready[c])
				s_next.tx_v[c] = 1'b0;
			if (stage_free && s_reg.rel[c] != '0 && txf_vld[c])
			begin
				txf_pop[c] = 1'b1;
				s_next.tx_v[c] = 1'b1;
				s_next.tx_d[c] = txf_dout[c];
				s_next.rel[c] = 7'(s_reg.rel[c] - 1'b1);
			end
			else if (stage_free && s_reg.sending[c] && s_reg.rel[c] == '0)
			begin
				if (s_reg.close_pend[c])
				begin
					// Framer appends CRC and closing flag
					s_next.tx_cl[c] = 1'b1;
					s_next.sending[c] = 1'b0;
					s_next.close_pend[c] = 1'b0;
					ev_set[c][HCF_EV_TX_SPACE] = 1'b1;
				end
				else if (tx_ready[c])
				begin
					// Framer sends seven ones, then fill
					s_next.tx_ab[c] = 1'b1;
					s_next.sending[c] = 1'b0;
					s_next.space_armed[c] = 1'b0;
					ev_set[c][HCF_EV_TX_UNDER] = 1'b1;
				end
			end
			if (s_reg.space_armed[c] && !s_reg.close_pend[c]
				&& txf_cnt[c] <= BANK_C)
			begin
				s_next.space_armed[c] = 1'b0;
				ev_set[c][HCF_EV_TX_SPACE] = 1'b1;
			end

			// Channel register writes
			if (wr && is_ch_fifo(bus_addr, c) && txf_rdy[c])
			begin
				// Overfilling is the host's fault; surplus bytes are dropped
				txf_push[c] = 1'b1;
				s_next.wr_cnt[c] = 7'(s_reg.wr_cnt[c] + 1'b1);
			end
			if (wr && is_ch_reg(bus_addr, c, HCF_OFS_FLAGS))
				s_next.ev_mask[c] = bus_din[HCF_NEV-1:0];
			cmd_hit = wr && is_ch_reg(bus_addr, c, HCF_OFS_CMD);
			if (cmd_hit && bus_din == HCF_CMD_RX_RELEASE
				&& s_reg.cur_valid[c])
			begin
				s_next.cur_valid[c] = 1'b0;
				s_next.disc[c] = s_reg.remain[c];
				s_next.remain[c] = '0;
				s_next.tally[c] = HCF_RST_BYTE;
			end
			if (cmd_hit && (bus_din == HCF_CMD_TX_GO
				|| bus_din == HCF_CMD_TX_GO_CLOSE))
			begin
				s_next.rel[c] = 7'(s_next.rel[c] + s_reg.wr_cnt[c]);
				s_next.wr_cnt[c] = '0;
				s_next.sending[c] = 1'b1;
				s_next.close_pend[c] = (bus_din == HCF_CMD_TX_GO_CLOSE);
				s_next.space_armed[c] = (bus_din == HCF_CMD_TX_GO);
			end
			if (cmd_hit && bus_din == HCF_CMD_TX_ABORT)
			begin
				txf_clr[c] = 1'b1;
				s_next.tx_ab[c] = s_reg.sending[c] || s_reg.tx_v[c];
				s_next.tx_v[c] = 1'b0;
				s_next.rel[c] = '0;
				s_next.wr_cnt[c] = '0;
				s_next.sending[c] = 1'b0;
				s_next.close_pend[c] = 1'b0;
				s_next.space_armed[c] = 1'b0;
				ev_set[c][HCF_EV_TX_SPACE] = 1'b1;
			end

			// Channel register reads
			if (rd && is_ch_fifo(bus_addr, c))
			begin
				// Reads past the delivered block return zero, no pop
				if (s_reg.cur_valid[c] && s_reg.remain[c] != '0)
				begin
					rxf_pop[c] = 1'b1;
					rbyte = rxf_dout[c];
					s_next.remain[c] = 6'(s_reg.remain[c] - 1'b1);
				end
				s_next.oe = 8'hff;
			end
			if (rd && is_ch_reg(bus_addr, c, HCF_OFS_FLAGS))
			begin
				ev_rdclr[c] = 1'b1;
				rbyte = 8'(ev_shown[c]);
				s_next.oe = 8'hff;
			end
			if (rd && is_ch_reg(bus_addr, c, HCF_OFS_CMD))
			begin
				rbyte[HCF_STAT_XFW_BIT] = (txf_cnt[c] <= BANK_C);
				rbyte[HCF_STAT_SEND_BIT] = s_reg.sending[c];
				s_next.oe = 8'hff;
			end
			if (rd && is_ch_reg(bus_addr, c, HCF_OFS_TALLY))
			begin
				rbyte = s_reg.cur_end[c] && s_reg.cur_valid[c]
					? s_reg.tally[c] : HCF_RST_BYTE;
				s_next.oe = 8'hff;
			end

			// Vector bit tracks the channel's shown flags
			vec[c] = (ev_shown[c] != '0);
			// Line stays low for flags left shown or newly shown here
			any_ev = any_ev || (vec[c] && !ev_rdclr[c]);
			// Hidden causes must not pull the line, even for one cycle
			any_ev = any_ev || (!s_reg.src_mask[c]
				&& (ev_set[c] & ~s_reg.ev_mask[c]) != '0);
		end

		if (rd && bus_addr == HCF_ADDR_VECTOR)
		begin
			if (s_reg.vis_sel)
			begin
				rbyte = {4'(vec), 4'h0};
				s_next.oe = 8'hf0;
			end
			else
			begin
				rbyte = {4'h0, 4'(vec)};
				s_next.oe = 8'h0f;
			end
		end
		if (rd && bus_addr == HCF_ADDR_CONFIG)
		begin
			rbyte[HCF_CFG_VIS_BIT] = s_reg.vis_sel;
			s_next.oe = 8'hff;
		end
		if (rd && bus_addr == HCF_ADDR_ADDR_CMP)
		begin
			rbyte = 8'(s_reg.acmp);
			s_next.oe = 8'hff;
		end
		if (rd && bus_addr == HCF_ADDR_SRC_MASK)
		begin
			rbyte = 8'(s_reg.src_mask);
			s_next.oe = 8'hff;
		end
		s_next.dout = rbyte;
		// Line follows flags as they stand after this cycle's read and sets
		s_next.int_n = !any_ev;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_reg <= '0;
			s_reg.int_n <= 1'b1;
		end
		else if (ce)
			s_reg <= s_next;
	end
endmodule : hcf_top

// ### verif/hcf_checker.sv
// Port-level timing checks for the channel data path
`timescale 1ns/100ps
module hcf_checker
	import hcf_pkg::*;
#(
	parameter int NCH = HCF_NCH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic bus_cs,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic [6:0] bus_addr,
	input wire logic [7:0] bus_din,
	input wire logic [7:0] bus_oe,
	input wire logic int_n,
	input wire logic [NCH-1:0] tx_valid,
	input wire logic [NCH*8-1:0] tx_data,
	input wire logic [NCH-1:0] tx_ready,
	input wire logic [NCH-1:0] tx_close,
	input wire logic [NCH-1:0] tx_abort
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire rd_go = ce && bus_cs && bus_rd;
	wire ab_go = ce && bus_cs && bus_wr && bus_addr == 7'h11
		&& bus_din == HCF_CMD_TX_ABORT;
	////////////////////////////////////////
	property p_vec_lane;
		rd_go && bus_addr == HCF_ADDR_VECTOR |=> bus_oe == 8'h0f || bus_oe == 8'hf0;
	endproperty
	a_vec_lane: assert property (p_vec_lane) else $error("vector lanes");
	property p_oe_idle;
		ce && !(bus_cs && bus_rd) |=> bus_oe == HCF_OE_NONE;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("bus driven idle");
	property p_flags_oe;
		rd_go && bus_addr == 7'h10 |=> bus_oe == 8'hff ##1 bus_oe == 8'h00;
	endproperty
	a_flags_oe: assert property (p_flags_oe) else $error("flags read oe");
	property p_reset;
		$fell(rst) |-> int_n && bus_oe == 8'h00 && tx_valid == '0;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state");
	property p_tx_hold;
		tx_valid[0] && !tx_ready[0] && !ab_go |=>
			tx_valid[0] && $stable(tx_data[7:0]);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
	property p_close;
		tx_close[0] |-> !tx_valid[0] ##1 !tx_close[0];
	endproperty
	a_close: assert property (p_close) else $error("close pulse");
	property p_abort_pulse;
		tx_abort[0] |-> !tx_close[0] ##1 !tx_abort[0];
	endproperty
	a_abort_pulse: assert property (p_abort_pulse) else $error("abort pulse");
	property p_abort_cmd;
		ab_go |-> ##[1:4] !tx_valid[0];
	endproperty
	a_abort_cmd: assert property (p_abort_cmd) else $error("abort kept data");
endmodule : hcf_checker

bind hcf_top hcf_checker #(.NCH(NCH)) hcf_checker_i (.clk(clk), .rst(rst),
	.ce(ce), .bus_cs(bus_cs), .bus_rd(bus_rd), .bus_wr(bus_wr),
	.bus_addr(bus_addr), .bus_din(bus_din), .bus_oe(bus_oe), .int_n(int_n),
	.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
	.tx_close(tx_close), .tx_abort(tx_abort));

// ### verif/hcf_framer_model.sv
// Serial framer stand-in: sends receive frames, takes transmit bytes
`timescale 1ns/100ps
module hcf_framer_model
	import hcf_pkg::*;
(
	input wire logic clk,
	input wire logic stall,
	output logic [HCF_NCH-1:0] rx_valid,
	output logic [HCF_NCH*8-1:0] rx_data,
	output logic [HCF_NCH-1:0] rx_last,
	output logic [HCF_NCH-1:0] rx_abort,
	output logic [HCF_NCH-1:0] rx_crc_ok,
	input wire logic [HCF_NCH-1:0] rx_ready,
	input wire logic [HCF_NCH-1:0] tx_valid,
	input wire logic [HCF_NCH*8-1:0] tx_data,
	output logic [HCF_NCH-1:0] tx_ready,
	input wire logic [HCF_NCH-1:0] tx_close,
	input wire logic [HCF_NCH-1:0] tx_abort
);
	logic [7:0] got[$];
	int closes = 0;
	int aborts = 0;
	assign tx_ready = {HCF_NCH{!stall}};
	initial
	begin
		rx_valid = '0;
		rx_data = '0;
		rx_last = '0;
		rx_abort = '0;
		rx_crc_ok = '0;
	end
	////////////////////////////////////////
	always @(posedge clk)
	begin
		if (tx_valid[0] && tx_ready[0])
			got.push_back(tx_data[7:0]);
		if (tx_close[0])
			closes++;
		if (tx_abort[0])
			aborts++;
	end
	task send_frame(input int n, input logic [7:0] first, input logic ab);
		int i;
		for (i = 0; i < n; i++)
		begin
			@(posedge clk) #1;
			rx_valid = 4'h1;
			rx_data = {24'h000000, first + i[7:0]};
		end
		@(posedge clk) #1;
		rx_last = 4'h1;
		rx_abort = {3'h0, ab};
		rx_crc_ok = {3'h0, !ab};
		// Status beat carries no byte, so the lane shows junk
		rx_data = ~rx_data;
		for (i = 0; i < 100 && rx_ready[0] !== 1'b1; i++)
			@(posedge clk) #1;
		@(posedge clk) #1;
		rx_valid = '0;
		rx_last = '0;
		rx_data = ~rx_data;
	endtask : send_frame
endmodule : hcf_framer_model

// ### verif/hdlc_channel_host_fifo_irq_test.sv
// Self-checking bench for the channel data path
`timescale 1ns/100ps
module hdlc_channel_host_fifo_irq_test;
	import hcf_pkg::*;
	localparam logic [6:0] FL = {2'b00, HCF_OFS_FLAGS};
	localparam logic [6:0] CMD = {2'b00, HCF_OFS_CMD};
	localparam logic [6:0] TL = {2'b00, HCF_OFS_TALLY};
	logic clk = 0;
	logic rst = 1;
	logic bus_cs = 0, bus_rd = 0, bus_wr = 0, stall = 0;
	logic [6:0] bus_addr = 7'h00;
	logic [7:0] bus_din = 8'h00;
	logic [7:0] bus_dout, bus_oe, d, o;
	logic int_n;
	logic [3:0] rx_valid, rx_last, rx_abort, rx_crc_ok, rx_ready;
	logic [3:0] tx_valid, tx_ready, tx_close, tx_abort;
	logic [31:0] rx_data, tx_data;
	int fail_count = 0;
	int checks_done = 0;
	always #5 clk = ~clk;
	hcf_top hcf_top_i (.clk(clk), .rst(rst), .ce(1'b1), .bus_cs(bus_cs),
		.bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr),
		.bus_din(bus_din), .bus_dout(bus_dout), .bus_oe(bus_oe),
		.int_n(int_n), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_last(rx_last), .rx_abort(rx_abort), .rx_crc_ok(rx_crc_ok),
		.rx_addr_ok(4'hf), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .tx_close(tx_close),
		.tx_abort(tx_abort));
	hcf_framer_model hcf_framer_model_i (.clk(clk), .stall(stall),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
		.rx_abort(rx_abort), .rx_crc_ok(rx_crc_ok), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.tx_close(tx_close), .tx_abort(tx_abort));
	////////////////////////////////////////
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop
	task acc(input logic w, input logic [6:0] a, input logic [7:0] v);
		@(posedge clk) #1;
		bus_cs = 1;
		bus_wr = w;
		bus_rd = !w;
		bus_addr = a;
		bus_din = v;
		@(posedge clk) #1;
		bus_cs = 0;
		bus_wr = 0;
		bus_rd = 0;
		d = bus_dout;
		o = bus_oe;
	endtask : acc
	task rdc(input logic [6:0] a, input logic [7:0] exp, input string what);
		acc(0, a, 8'h00);
		chk(what, d, exp);
	endtask : rdc
	task wait_int;
		int i;
		for (i = 0; i < 300 && int_n !== 1'b0; i++)
			@(posedge clk) #1;
		if (int_n !== 1'b0)
		begin
			fail_count++;
			report_and_stop();
		end
	endtask : wait_int
	////////////////////////////////////////
	task s_idle;
		rdc(HCF_ADDR_VECTOR, 8'h00, "vector");
		rdc(FL, 8'h00, "flags");
		rdc(TL, 8'h00, "tally");
		acc(0, CMD, 8'h00);
		chk("status", d & 8'h44, 8'h40);
		chk("int", {7'h00, int_n}, 8'h01);
	endtask : s_idle
	task s_short;
		hcf_framer_model_i.send_frame(2, 8'ha1, 1'b0);
		wait_int();
		rdc(HCF_ADDR_VECTOR, 8'h01, "vector");
		rdc(FL, 8'h01, "flags");
		@(posedge clk) #1;
		chk("int", {7'h00, int_n}, 8'h01);
		rdc(TL, 8'h03, "tally");
		rdc(7'h00, 8'ha1, "byte 0");
		rdc(7'h00, 8'ha2, "byte 1");
		rdc(7'h00, 8'h20, "status byte");
		acc(1, CMD, HCF_CMD_RX_RELEASE);
		rdc(TL, 8'h00, "tally after release");
	endtask : s_short
	task s_mask;
		acc(1, HCF_ADDR_SRC_MASK, 8'h01);
		acc(1, FL, 8'h01);
		hcf_framer_model_i.send_frame(1, 8'h5a, 1'b1);
		repeat (20) @(posedge clk) #1;
		chk("int masked", {7'h00, int_n}, 8'h01);
		rdc(HCF_ADDR_VECTOR, 8'h00, "masked vector");
		rdc(FL, 8'h00, "masked flags");
		acc(1, HCF_ADDR_SRC_MASK, 8'h00);
		repeat (10) @(posedge clk) #1;
		chk("int cause masked", {7'h00, int_n}, 8'h01);
		acc(1, HCF_ADDR_CONFIG, 8'h20);
		acc(1, FL, 8'h00);
		wait_int();
		rdc(HCF_ADDR_VECTOR, 8'h10, "upper vector");
		chk("vector lanes", o, 8'hf0);
		rdc(FL, 8'h01, "pending flags");
		rdc(TL, 8'h02, "tally");
		rdc(7'h00, 8'h5a, "byte");
		rdc(7'h00, 8'h80, "aborted status");
		acc(1, CMD, HCF_CMD_RX_RELEASE);
		acc(1, HCF_ADDR_CONFIG, 8'h00);
	endtask : s_mask
	task s_long;
		int i;
		hcf_framer_model_i.send_frame(33, 8'h00, 1'b0);
		wait_int();
		rdc(FL, 8'h02, "block flags");
		rdc(TL, 8'h00, "tally in block");
		for (i = 0; i < 32; i++)
			rdc(7'h00, i[7:0], "block byte");
		acc(1, CMD, HCF_CMD_RX_RELEASE);
		wait_int();
		rdc(FL, 8'h01, "end flags");
		rdc(TL, 8'h22, "tally");
		rdc(7'h00, 8'h20, "last byte");
		rdc(7'h00, 8'h20, "status byte");
		acc(1, CMD, HCF_CMD_RX_RELEASE);
	endtask : s_long
	task s_tx;
		int i;
		acc(1, 7'h00, 8'h31);
		acc(1, 7'h00, 8'h32);
		acc(1, CMD, HCF_CMD_TX_GO_CLOSE);
		wait_int();
		rdc(FL, 8'h08, "close flags");
		chk("closes", hcf_framer_model_i.closes[7:0], 8'h01);
		acc(1, 7'h00, 8'h33);
		acc(1, CMD, HCF_CMD_TX_GO);
		for (i = 0; i < 50 && hcf_framer_model_i.aborts == 0; i++)
			@(posedge clk) #1;
		repeat (3) @(posedge clk) #1;
		rdc(FL, 8'h18, "underrun flags");
		chk("sent 0", hcf_framer_model_i.got[0], 8'h31);
		chk("sent 1", hcf_framer_model_i.got[1], 8'h32);
		chk("sent 2", hcf_framer_model_i.got[2], 8'h33);
		stall = 1;
		acc(1, 7'h00, 8'h34);
		acc(1, CMD, HCF_CMD_TX_GO);
		acc(1, CMD, HCF_CMD_TX_ABORT);
		stall = 0;
		repeat (5) @(posedge clk) #1;
		chk("aborts", hcf_framer_model_i.aborts[7:0], 8'h02);
		rdc(FL, 8'h08, "abort flags");
		acc(0, CMD, 8'h00);
		chk("status", d & 8'h44, 8'h40);
	endtask : s_tx
	initial
	begin
		repeat (4) @(posedge clk);
		#1;
		rst = 0;
		s_idle();
		s_short();
		s_mask();
		s_long();
		s_tx();
		report_and_stop();
	end
endmodule : hdlc_channel_host_fifo_irq_test
